//--- logic/telemetry_pkg.sv
// constants shared by the supply and channel current telemetry block
package telemetry_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned REFRESH_MS     = 100;
  localparam int unsigned REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_MS;

  // ************************************************************
  // word layout and reset values
  // ************************************************************
  localparam int unsigned   CODE_W     = 14;
  localparam int unsigned   CHAN_N     = 4;
  localparam logic [13:0]   CODE_RST   = 14'h0000;
  localparam logic [1:0]    PAD_ZERO   = 2'h0;
  localparam logic [7:0]    BYTE_ZERO  = 8'h00;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0]    CMD_SUPPLY = 8'h2E;
  localparam logic [7:0]    CMD_CUR1   = 8'h30;
  localparam logic [7:0]    CMD_CUR2   = 8'h34;
  localparam logic [7:0]    CMD_CUR3   = 8'h38;
  localparam logic [7:0]    CMD_CUR4   = 8'h3C;

  // ************************************************************
  // serial port
  // ************************************************************
  localparam logic [6:0]    DEV_ADDR_DFLT = 7'h20;
  localparam logic [3:0]    BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]    BIT_CNT_RST   = 4'h0;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ACK_ADDR = 7'b0000100,
    ST_CMD      = 7'b0001000,
    ST_ACK_CMD  = 7'b0010000,
    ST_TX       = 7'b0100000,
    ST_RX_ACK   = 7'b1000000
  } port_state_t;

endpackage : telemetry_pkg

//--- logic/current_slot.sv
// one channel current reading holder
`timescale 1ns/1ns
module current_slot (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // channel condition
  input  wire logic        tick_i,
  input  wire logic        powered_i,
  input  wire logic        disable_i,
  input  wire logic        diag_i,
  // measurements
  input  wire logic [13:0] conv_code_i,
  input  wire logic        conv_done_i,
  input  wire logic [13:0] class_code_i,
  input  wire logic        class_done_i,
  // reading
  output logic      [13:0] reading_o,
  output logic             class_scale_o
);

  logic [13:0] reading_r;
  logic [13:0] reading_nxt;
  logic        class_r;
  logic        class_nxt;

  // ************************************************************
  // next reading
  // ************************************************************
  always_comb begin
    reading_nxt = reading_r;
    class_nxt   = class_r;
    if (class_done_i) begin
      reading_nxt = class_code_i; // R10
      class_nxt   = 1'b1; // R11
    end else if (disable_i) begin
      reading_nxt = telemetry_pkg::CODE_RST; // R10
      class_nxt   = 1'b0; // R10
    end else if (diag_i) begin
      if (conv_done_i) begin
        reading_nxt = conv_code_i; // R7
        class_nxt   = 1'b0;
      end
    end else if (powered_i && tick_i) begin
      reading_nxt = conv_code_i; // R4 R5
      class_nxt   = 1'b0; // R10
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reading_r <= telemetry_pkg::CODE_RST; // R6
      class_r   <= 1'b0;
    end else begin
      reading_r <= reading_nxt;
      class_r   <= class_nxt;
    end
  end

  assign reading_o     = reading_r;
  assign class_scale_o = class_r; // R11

endmodule : current_slot

//--- logic/supply_and_channel_current_telemetry.sv
// supply voltage and channel current telemetry with serial read port
// Operation
// [R1] supply voltage is a 14-bit result fetched as a two-byte read
// [R2] supply code counts 3.662 mV per step, 60 V full scale
// [R3] channel currents answer commands 30h 34h 38h 3Ch, low byte first
// [R4] channel current is 14 bits, refreshed about every 100 ms when powered
// [R5] powered current code counts 89.5 uA, 1.46 A full scale
// [R6] all telemetry bits are read-only and zero after reset
// [R7] diagnostic mode keeps the last measurement taken on the channel
// [R8] low byte holds bits 7..0, high byte bits 13..8, top two zero
// [R9] supply voltage answers command 2Eh, two bytes, low byte first
// [R10] class current shown after classification until powered reading or disable
// [R11] class current reading uses a tenfold finer 8.95 uA step
`timescale 1ns/1ns
module supply_and_channel_current_telemetry #(
  parameter int unsigned REFRESH_CYCLES = telemetry_pkg::REFRESH_CYCLES,
  parameter logic [6:0]  DEV_ADDR       = telemetry_pkg::DEV_ADDR_DFLT
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // supply conversion
  input  wire logic [13:0] supply_code_i,
  input  wire logic        supply_done_i,
  // channel conditions
  input  wire logic [3:0]  ch_powered_i,
  input  wire logic [3:0]  ch_disable_i,
  input  wire logic [3:0]  ch_diag_i,
  // channel conversions
  input  wire logic [55:0] ch_conv_code_i,
  input  wire logic [3:0]  ch_conv_done_i,
  input  wire logic [55:0] ch_class_code_i,
  input  wire logic [3:0]  ch_class_done_i,
  // status
  output logic      [3:0]  ch_class_scale_o,
  output logic             refresh_tick_o
);

  localparam int unsigned CW = telemetry_pkg::CODE_W;

  // ************************************************************
  // refresh divider
  // ************************************************************
  logic [31:0] div_r;
  logic [31:0] div_nxt;
  logic        tick;

  assign tick = (div_r == REFRESH_CYCLES - 1);

  always_comb begin
    div_nxt = tick ? 32'h00000000 : div_r + 32'h00000001; // R4
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 32'h00000000;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign refresh_tick_o = tick;

  // ************************************************************
  // supply reading
  // ************************************************************
  logic [13:0] supply_r;
  logic [13:0] supply_nxt;

  always_comb begin
    supply_nxt = supply_done_i ? supply_code_i : supply_r; // R1 R2
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_r <= telemetry_pkg::CODE_RST; // R6
    end else begin
      supply_r <= supply_nxt;
    end
  end

  // ************************************************************
  // channel readings
  // ************************************************************
  logic [13:0] cur [telemetry_pkg::CHAN_N];

  for (genvar g = 0; g < telemetry_pkg::CHAN_N; g++) begin : g_ch
    current_slot u_slot (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .tick_i        (tick),
      .powered_i     (ch_powered_i[g]),
      .disable_i     (ch_disable_i[g]),
      .diag_i        (ch_diag_i[g]),
      .conv_code_i   (ch_conv_code_i[g*CW +: CW]),
      .conv_done_i   (ch_conv_done_i[g]),
      .class_code_i  (ch_class_code_i[g*CW +: CW]),
      .class_done_i  (ch_class_done_i[g]),
      .reading_o     (cur[g]),
      .class_scale_o (ch_class_scale_o[g])
    );
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], scl_i};
      sda_sy_r <= {sda_sy_r[0], sda_i};
      scl_d_r  <= scl_sy_r[1];
      sda_d_r  <= sda_sy_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_s    = scl_sy_r[1];
  assign sda_s    = sda_sy_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ************************************************************
  // register read selection
  // ************************************************************
  logic [7:0]  cmd_r;
  logic [15:0] word_sel;

  always_comb begin
    case (cmd_r)
      telemetry_pkg::CMD_SUPPLY: word_sel = {telemetry_pkg::PAD_ZERO, supply_r}; // R9 R8
      telemetry_pkg::CMD_CUR1:   word_sel = {telemetry_pkg::PAD_ZERO, cur[0]}; // R3 R8
      telemetry_pkg::CMD_CUR2:   word_sel = {telemetry_pkg::PAD_ZERO, cur[1]}; // R3
      telemetry_pkg::CMD_CUR3:   word_sel = {telemetry_pkg::PAD_ZERO, cur[2]}; // R3
      telemetry_pkg::CMD_CUR4:   word_sel = {telemetry_pkg::PAD_ZERO, cur[3]}; // R3
      default:                   word_sel = {telemetry_pkg::BYTE_ZERO, telemetry_pkg::BYTE_ZERO};
    endcase
  end

  // ************************************************************
  // serial port state machine
  // ************************************************************
  telemetry_pkg::port_state_t st_r;
  telemetry_pkg::port_state_t st_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic        rw_r;
  logic        rw_nxt;
  logic [7:0]  cmd_nxt;
  logic        hi_r;
  logic        hi_nxt;
  logic [7:0]  hold_r;
  logic [7:0]  hold_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        oe_r;
  logic        oe_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    rw_nxt   = rw_r;
    cmd_nxt  = cmd_r;
    hi_nxt   = hi_r;
    hold_nxt = hold_r;
    nack_nxt = nack_r;
    oe_nxt   = oe_r;
    if (start_c) begin
      st_nxt  = telemetry_pkg::ST_ADDR;
      cnt_nxt = telemetry_pkg::BIT_CNT_RST;
      oe_nxt  = 1'b0;
    end else if (stop_c) begin
      st_nxt = telemetry_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        telemetry_pkg::ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        telemetry_pkg::ST_ADDR, telemetry_pkg::ST_CMD: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == telemetry_pkg::BITS_PER_BYTE) begin
            if (st_r == telemetry_pkg::ST_CMD) begin
              cmd_nxt = sh_r;
              hi_nxt  = 1'b0;
              st_nxt  = telemetry_pkg::ST_ACK_CMD;
              oe_nxt  = 1'b1;
            end else if (sh_r[7:1] == DEV_ADDR) begin
              rw_nxt = sh_r[0];
              st_nxt = telemetry_pkg::ST_ACK_ADDR;
              oe_nxt = 1'b1;
            end else begin
              st_nxt = telemetry_pkg::ST_IDLE;
            end
          end
        end
        telemetry_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_nxt = telemetry_pkg::BIT_CNT_RST;
            if (rw_r) begin
              sh_nxt   = hi_r ? hold_r : word_sel[7:0]; // R8
              hold_nxt = hi_r ? hold_r : word_sel[15:8];
              oe_nxt   = hi_r ? ~hold_r[7] : ~word_sel[7];
              st_nxt   = telemetry_pkg::ST_TX;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = telemetry_pkg::ST_CMD;
            end
          end
        end
        telemetry_pkg::ST_ACK_CMD: begin
          if (scl_fall) begin
            oe_nxt = 1'b0; // R6
            st_nxt = telemetry_pkg::ST_IDLE;
          end
        end
        telemetry_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == telemetry_pkg::BITS_PER_BYTE) begin
              oe_nxt = 1'b0;
              st_nxt = telemetry_pkg::ST_RX_ACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        telemetry_pkg::ST_RX_ACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            cnt_nxt = telemetry_pkg::BIT_CNT_RST;
            hi_nxt  = ~hi_r; // R3 R9
            if (nack_r) begin
              st_nxt = telemetry_pkg::ST_IDLE;
            end else begin
              sh_nxt   = hi_r ? word_sel[7:0] : hold_r;
              hold_nxt = hi_r ? word_sel[15:8] : hold_r;
              oe_nxt   = hi_r ? ~word_sel[7] : ~hold_r[7];
              st_nxt   = telemetry_pkg::ST_TX;
            end
          end
        end
        default: begin
          st_nxt = telemetry_pkg::ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r   <= telemetry_pkg::ST_IDLE;
      cnt_r  <= telemetry_pkg::BIT_CNT_RST;
      sh_r   <= telemetry_pkg::BYTE_ZERO;
      rw_r   <= 1'b0;
      cmd_r  <= telemetry_pkg::BYTE_ZERO;
      hi_r   <= 1'b0;
      hold_r <= telemetry_pkg::BYTE_ZERO;
      nack_r <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      rw_r   <= rw_nxt;
      cmd_r  <= cmd_nxt;
      hi_r   <= hi_nxt;
      hold_r <= hold_nxt;
      nack_r <= nack_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // open-drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_r;

endmodule : supply_and_channel_current_telemetry

//--- bench/i2c_host.sv
// serial host model reading the telemetry port
`timescale 1ns/1ns
module i2c_host #(
  parameter logic [6:0] ADDR = 7'h20
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  // ************************************************************
  // bus primitives, pull_o high pulls the data line low
  // ************************************************************
  initial {scl_o, pull_o} = 2'h2;
  task automatic sp(input logic s, input logic p);
    scl_o = s;
    pull_o = p;
    repeat (8) @(negedge clk_i);
  endtask : sp
  task automatic start();
    sp(1'h0, pull_o);
    sp(1'h0, 1'h0);
    sp(1'h1, 1'h0);
    sp(1'h1, 1'h1);
  endtask : start
  task automatic stop();
    sp(1'h0, pull_o);
    sp(1'h0, 1'h1);
    sp(1'h1, 1'h1);
    sp(1'h1, 1'h0);
  endtask : stop
  task automatic rbit(output logic b);
    sp(1'h0, pull_o);
    sp(1'h0, 1'h0);
    sp(1'h1, 1'h0);
    b = sda_i;
  endtask : rbit
  task automatic wbyte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      sp(1'h0, pull_o);
      sp(1'h0, ~d[i]);
      sp(1'h1, ~d[i]);
    end
    rbit(nack);
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic b;
    for (int i = 0; i < 8; i++) begin
      rbit(b);
      d = {d[6:0], b};
    end
    sp(1'h0, pull_o);
    sp(1'h0, ~last);
    sp(1'h1, ~last);
  endtask : rbyte
  task automatic rd(input logic [7:0] cmd, output logic [15:0] w);
    logic n;
    start();
    wbyte({ADDR, 1'h0}, n);
    wbyte(cmd, n);
    start();
    wbyte({ADDR, 1'h1}, n);
    rbyte(w[7:0], 1'h0);
    rbyte(w[15:8], 1'h1);
    stop();
  endtask : rd
endmodule : i2c_host

//--- bench/telemetry_chk.sv
// port checker for the telemetry block
`timescale 1ns/1ns
module telemetry_chk #(
  parameter int unsigned REFRESH_CYCLES = telemetry_pkg::REFRESH_CYCLES
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sda_oe_o,
  input wire logic [3:0] ch_powered_i,
  input wire logic [3:0] ch_disable_i,
  input wire logic [3:0] ch_diag_i,
  input wire logic [3:0] ch_conv_done_i,
  input wire logic [3:0] ch_class_done_i,
  input wire logic [3:0] ch_class_scale_o,
  input wire logic       refresh_tick_o
);
  // ************************************************************
  // helper logic and properties
  // ************************************************************
  logic [3:0]  set_m;
  logic [3:0]  clr_m;
  logic [3:0]  dis_m;
  int unsigned cnt_r;
  int unsigned cnt_nxt;
  logic        seen_r;
  logic        seen_nxt;
  assign set_m = ch_class_done_i;
  assign dis_m = ch_disable_i & ~ch_class_done_i;
  assign clr_m = ~ch_class_done_i & ({4{refresh_tick_o}} & ch_powered_i & ~ch_diag_i
               | ch_diag_i & ch_conv_done_i);
  always_comb begin
    cnt_nxt = refresh_tick_o ? 32'h0 : cnt_r + 32'h1;
    seen_nxt = seen_r | refresh_tick_o;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0;
      seen_r <= 1'h0;
    end else begin
      cnt_r <= cnt_nxt;
      seen_r <= seen_nxt;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst;
    disable iff (1'h0) rst_i |-> ch_class_scale_o == 4'h0 && !sda_oe_o;
  endproperty
  property p_set;
    set_m != 4'h0 |=> (ch_class_scale_o & $past(set_m)) == $past(set_m);
  endproperty
  property p_dis;
    dis_m != 4'h0 |=> (ch_class_scale_o & $past(dis_m)) == 4'h0;
  endproperty
  property p_upd;
    clr_m != 4'h0 |=> (ch_class_scale_o & $past(clr_m)) == 4'h0;
  endproperty
  property p_rise;
    (ch_class_scale_o & ~$past(ch_class_scale_o) & ~$past(ch_class_done_i)) == 4'h0;
  endproperty
  property p_per;
    refresh_tick_o && seen_r |-> cnt_r == REFRESH_CYCLES - 1;
  endproperty
  property p_due;
    cnt_r < REFRESH_CYCLES + 1;
  endproperty
  property p_oe;
    $rose(sda_oe_o) |-> !scl_i;
  endproperty
  a_rst: assert property (p_rst) else $error("flags not clear in reset");
  a_set: assert property (p_set) else $error("class flag not set");
  a_dis: assert property (p_dis) else $error("class flag kept on disable");
  a_upd: assert property (p_upd) else $error("class flag kept on update");
  a_rise: assert property (p_rise) else $error("class flag without cause");
  a_per: assert property (p_per) else $error("refresh period wrong");
  a_due: assert property (p_due) else $error("refresh missing");
  a_oe: assert property (p_oe) else $error("data driven while clock high");
  c_cls: cover property (set_m != 4'h0);
  c_tick: cover property (refresh_tick_o);
  c_oe: cover property ($rose(sda_oe_o));
endmodule : telemetry_chk
bind supply_and_channel_current_telemetry telemetry_chk #(
  .REFRESH_CYCLES(REFRESH_CYCLES)) watch (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .ch_powered_i(ch_powered_i), .ch_disable_i(ch_disable_i),
  .ch_diag_i(ch_diag_i), .ch_conv_done_i(ch_conv_done_i), .ch_class_done_i(ch_class_done_i),
  .ch_class_scale_o(ch_class_scale_o), .refresh_tick_o(refresh_tick_o));

//--- bench/supply_and_channel_current_telemetry_tb.sv
// self-checking bench for the telemetry block
`timescale 1ns/1ns
module supply_and_channel_current_telemetry_tb;
  // ************************************************************
  // setup and helpers
  // ************************************************************
  localparam int unsigned RC = 50;
  localparam logic [6:0]  ADR = telemetry_pkg::DEV_ADDR_DFLT;
  logic        clk_i, rst_i, scl, pull, sda, sda_oe, sda_q, sup_done, tick, n;
  logic [13:0] sup_code;
  logic [3:0]  pwr, dis, diag, cdone, kdone, kscale;
  logic [55:0] ccode, kcode;
  logic [15:0] w;
  logic [13:0] v [4];
  int          fails, samples_checked;
  assign sda = ~(pull | (sda_oe & ~sda_q));
  i2c_host #(.ADDR(ADR)) host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  supply_and_channel_current_telemetry #(.REFRESH_CYCLES(RC), .DEV_ADDR(ADR)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_q), .sda_oe_o(sda_oe),
    .supply_code_i(sup_code), .supply_done_i(sup_done), .ch_powered_i(pwr),
    .ch_disable_i(dis), .ch_diag_i(diag), .ch_conv_code_i(ccode), .ch_conv_done_i(cdone),
    .ch_class_code_i(kcode), .ch_class_done_i(kdone), .ch_class_scale_o(kscale),
    .refresh_tick_o(tick));
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [15:0] word(input logic [13:0] c);
    return {2'h0, c};
  endfunction : word
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic nc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : nc
  task automatic wait_tick();
    for (int k = 0; k < 2 * RC && tick !== 1'h1; k++) nc(1);
    nc(1);
  endtask : wait_tick
  task automatic rdc(input int c, input logic [13:0] e);
    host.rd(8'h30 + 8'(4 * c), w);
    chk("current", w, word(e));
  endtask : rdc
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    rst_i = 1'h1;
    {sup_done, pwr, dis, diag, cdone, kdone, sup_code, ccode, kcode} = '0;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'hBD31EFFD));
    nc(5);
    rst_i = 1'h0;
    nc(5);
    for (int c = 0; c < 4; c++) rdc(c, 14'h0);
    host.rd(8'h2E, w);
    chk("supply", w, 16'h0);
    for (int j = 0; j < 2; j++) begin
      sup_code = j == 0 ? 14'h3FFF : 14'($urandom);
      sup_done = 1'h1;
      nc(1);
      sup_done = 1'h0;
      host.rd(8'h2E, w);
      chk("supply", w, word(sup_code));
    end
    for (int c = 0; c < 4; c++) v[c] = 14'($urandom);
    v[3] = 14'h3FFF;
    ccode = {v[3], v[2], v[1], v[0]};
    pwr = 4'hF;
    wait_tick();
    for (int c = 0; c < 4; c++) rdc(c, v[c]);
    pwr = 4'hD;
    kcode[27:14] = 14'($urandom);
    kdone = 4'h2;
    nc(1);
    kdone = 4'h0;
    nc(1);
    chk("class flag", 16'(kscale), 16'h2);
    rdc(1, kcode[27:14]);
    pwr = 4'hF;
    wait_tick();
    chk("class flag", 16'(kscale), 16'h0);
    rdc(1, v[1]);
    pwr = 4'hF;
    diag = 4'h4;
    v[2] = 14'($urandom);
    ccode[41:28] = v[2];
    cdone = 4'h4;
    nc(1);
    cdone = 4'h0;
    ccode[41:28] = ~v[2];
    wait_tick();
    rdc(2, v[2]);
    pwr = 4'h0;
    kdone = 4'h1;
    nc(1);
    kdone = 4'h0;
    dis = 4'h1;
    nc(1);
    dis = 4'h0;
    nc(1);
    chk("class flag", 16'(kscale), 16'h0);
    rdc(0, 14'h0);
    host.start();
    host.wbyte({ADR, 1'h0}, n);
    chk("address ack", 16'(n), 16'h0);
    host.wbyte(8'h30, n);
    host.wbyte(8'hA5, n);
    chk("write nack", 16'(n), 16'h1);
    host.stop();
    host.start();
    host.wbyte({ADR ^ 7'h01, 1'h0}, n);
    chk("foreign nack", 16'(n), 16'h1);
    host.stop();
    rdc(0, 14'h0);
    host.rd(8'h31, w);
    chk("unmapped", w, 16'h0);
    rst_i = 1'h1;
    nc(2);
    rst_i = 1'h0;
    nc(5);
    rdc(3, 14'h0);
    host.rd(8'h2E, w);
    chk("supply", w, 16'h0);
    give_verdict();
  end
  initial begin
    #(100 * 60000);
    fails++;
    give_verdict();
  end
endmodule : supply_and_channel_current_telemetry_tb
